// [rtl/fdcp_defines.svh]
// constants for the flash driver control-pin logic
`ifndef FDCP_DEFINES_SVH
`define FDCP_DEFINES_SVH
// serial target address, seven bits (write byte 0x60, read byte 0x61)
`define FDCP_TARGET_ADDR   7'h30
`define FDCP_RW_READ       1'b1
// bit counter figures for one serial byte
`define FDCP_BITS_PER_BYTE 4'h8
`define FDCP_CNT_ZERO      4'h0
`define FDCP_CNT_ONE       4'h1
// written command byte: bit 0 requests assist light
`define FDCP_CMD_ASSIST    0
// read status byte layout
`define FDCP_STAT_OVP      0
`define FDCP_STAT_TWO_LED  1
`define FDCP_BYTE_ZERO     8'h00
`define FDCP_SYNC_STAGES   2
`endif

// [rtl/fdcp_pkg.sv]
// types shared by the flash driver control-pin logic
package fdcp_pkg;
   // raw control pins and comparator levels, in synchroniser order
   typedef struct packed {
      logic if_select;
      logic clock_or_first_enable;
      logic data_or_second_enable;
      logic torch;
      logic tx_mask;
      logic strobe;
      logic ovp_comp;
      logic led_two;
   } fdcp_pins_s;

   typedef enum logic [2:0] {
      FDCP_MODE_OFF      = 3'b000,
      FDCP_MODE_TORCH    = 3'b001,
      FDCP_MODE_ASSIST   = 3'b010,
      FDCP_MODE_RESERVED = 3'b011,
      FDCP_MODE_FLASH    = 3'b100
   } fdcp_mode_e;

   typedef enum logic [1:0] {
      FDCP_CUR_OFF  = 2'b00,
      FDCP_CUR_LOW  = 2'b01,
      FDCP_CUR_HIGH = 2'b10
   } fdcp_cur_e;

   typedef enum logic [2:0] {
      FDCP_SER_IDLE  = 3'b000,
      FDCP_SER_ADDR  = 3'b001,
      FDCP_SER_ACK_A = 3'b010,
      FDCP_SER_WR    = 3'b011,
      FDCP_SER_ACK_W = 3'b100,
      FDCP_SER_RD    = 3'b101,
      FDCP_SER_RACK  = 3'b110
   } fdcp_ser_e;

   // led drive request towards the analog current source
   typedef struct packed {
      fdcp_mode_e mode;
      fdcp_cur_e  current;
      logic       enable;
   } fdcp_drive_s;
endpackage

// [rtl/fdcp_sync.sv]
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module fdcp_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   if (WIDTH < 1) begin : g_bad_width
      $error("fdcp_sync: WIDTH must be at least one");
   end

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] stable_reg;

   // ----------------------------------------------------------------
   // two flops; the first is seen by the second only
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg   <= '0;
         stable_reg <= '0;
      end else begin
         meta_reg   <= async_in;
         stable_reg <= meta_reg;
      end
   end

   assign sync_out = stable_reg;
endmodule
`default_nettype wire

// [rtl/fdcp_top.sv]
// control-pin logic of a dual led flash driver
//
// Notes on behaviour
// RL1: torch only when neither flash nor assist
// RL2: transmit mask drops flash to low current
// RL3: serial mode: strobe pin is camera input
// RL4: two-bit mode: strobe drives led count
// RL5: select low two-bit, high serial interface
// RL6: two-bit mode, both enables low: shutdown (torch pin high still gives torch)
// RL7: data pin: second enable or serial data
// RL8: clock pin: first enable or serial clock
// RL9: overvoltage comparator latches fault, led off
// RL10: enable bits pick shutdown, assist, reserved, flash
// RL11: answer serial address 0x60 write, 0x61 read
// RL12: masked flash stays flash, current restored after
// RL13: all control pins pass two flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "fdcp_defines.svh"
module fdcp_top (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire fdcp_pkg::fdcp_pins_s pins_in,
   output logic                     data_or_second_enable_out,
   output logic                     data_or_second_enable_oe,
   output logic                     strobe_out,
   output logic                     strobe_oe,
   output fdcp_pkg::fdcp_drive_s    led_anode_drive,
   output logic                     ovp_fault,
   output logic [7:0]               rx_byte,
   output logic                     rx_valid
);
   fdcp_pkg::fdcp_pins_s pins;

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   fdcp_sync #(
      .WIDTH ($bits(fdcp_pkg::fdcp_pins_s))
   ) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (pins_in),
      .sync_out (pins)
   ); // RL13

   logic serial_mode;
   logic first_enable_bit;
   logic second_enable_bit;
   assign serial_mode       = pins.if_select; // RL5
   assign first_enable_bit  = pins.clock_or_first_enable; // RL8
   assign second_enable_bit = pins.data_or_second_enable; // RL7

   // ----------------------------------------------------------------
   // serial clock and data edges
   // ----------------------------------------------------------------
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   // edges taken from the second flop and its delayed copy only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= pins.clock_or_first_enable;
         sda_prev_reg <= pins.data_or_second_enable;
      end
   end

   assign scl_rise   = serial_mode & ~scl_prev_reg
                       & pins.clock_or_first_enable; // RL8
   assign scl_fall   = serial_mode & scl_prev_reg
                       & ~pins.clock_or_first_enable;
   assign start_cond = serial_mode & scl_prev_reg
                       & pins.clock_or_first_enable
                       & sda_prev_reg & ~pins.data_or_second_enable;
   assign stop_cond  = serial_mode & scl_prev_reg
                       & pins.clock_or_first_enable
                       & ~sda_prev_reg & pins.data_or_second_enable;

   // ----------------------------------------------------------------
   // serial target state machine
   // ----------------------------------------------------------------
   fdcp_pkg::fdcp_ser_e ser_reg;
   fdcp_pkg::fdcp_ser_e ser_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic       drive_low_reg;
   logic       drive_low_next;
   logic       nack_reg;
   logic       nack_next;
   logic       assist_req_reg;
   logic       assist_req_next;
   logic [7:0] rx_byte_reg;
   logic [7:0] rx_byte_next;
   logic       rx_valid_reg;
   logic       rx_valid_next;
   logic [7:0] status_byte;

   // status returned on reads: fault and led count
   always_comb begin
      status_byte                     = `FDCP_BYTE_ZERO;
      status_byte[`FDCP_STAT_OVP]     = ovp_fault;
      status_byte[`FDCP_STAT_TWO_LED] = pins.led_two;
   end

   // next state of the serial target; bits sampled on rising clock,
   // data line changed only after the falling clock edge
   always_comb begin
      ser_next        = ser_reg;
      shift_next      = shift_reg;
      tx_next         = tx_reg;
      cnt_next        = cnt_reg;
      drive_low_next  = drive_low_reg;
      nack_next       = nack_reg;
      assist_req_next = assist_req_reg;
      rx_byte_next    = rx_byte_reg;
      rx_valid_next   = 1'b0;
      if (!serial_mode || stop_cond) begin
         ser_next       = fdcp_pkg::FDCP_SER_IDLE;
         drive_low_next = 1'b0;
      end else if (start_cond) begin
         ser_next       = fdcp_pkg::FDCP_SER_ADDR;
         cnt_next       = `FDCP_CNT_ZERO;
         drive_low_next = 1'b0;
      end else begin
         unique case (ser_reg)
            fdcp_pkg::FDCP_SER_IDLE: begin
               drive_low_next = 1'b0;
            end
            fdcp_pkg::FDCP_SER_ADDR,
            fdcp_pkg::FDCP_SER_WR: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0],
                                pins.data_or_second_enable};
                  cnt_next   = cnt_reg + `FDCP_CNT_ONE;
               end else if (scl_fall && cnt_reg == `FDCP_BITS_PER_BYTE) begin
                  cnt_next = `FDCP_CNT_ZERO;
                  if (ser_reg == fdcp_pkg::FDCP_SER_WR) begin
                     drive_low_next  = 1'b1;
                     ser_next        = fdcp_pkg::FDCP_SER_ACK_W;
                     rx_byte_next    = shift_reg;
                     rx_valid_next   = 1'b1;
                     assist_req_next = shift_reg[`FDCP_CMD_ASSIST];
                  end else if (shift_reg[7:1] == `FDCP_TARGET_ADDR) begin
                     drive_low_next = 1'b1; // RL11
                     ser_next       = fdcp_pkg::FDCP_SER_ACK_A;
                  end else begin
                     ser_next = fdcp_pkg::FDCP_SER_IDLE;
                  end
               end
            end
            fdcp_pkg::FDCP_SER_ACK_A: begin
               if (scl_fall) begin
                  cnt_next = `FDCP_CNT_ZERO;
                  if (shift_reg[0] == `FDCP_RW_READ) begin
                     ser_next       = fdcp_pkg::FDCP_SER_RD; // RL11
                     tx_next        = status_byte;
                     drive_low_next = ~status_byte[7];
                  end else begin
                     ser_next       = fdcp_pkg::FDCP_SER_WR;
                     drive_low_next = 1'b0;
                  end
               end
            end
            fdcp_pkg::FDCP_SER_ACK_W: begin
               if (scl_fall) begin
                  ser_next       = fdcp_pkg::FDCP_SER_WR;
                  drive_low_next = 1'b0;
               end
            end
            fdcp_pkg::FDCP_SER_RD: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + `FDCP_CNT_ONE;
               end else if (scl_fall) begin
                  if (cnt_reg == `FDCP_BITS_PER_BYTE) begin
                     ser_next       = fdcp_pkg::FDCP_SER_RACK;
                     drive_low_next = 1'b0;
                  end else begin
                     tx_next        = {tx_reg[6:0], 1'b0};
                     drive_low_next = ~tx_reg[6];
                  end
               end
            end
            fdcp_pkg::FDCP_SER_RACK: begin
               if (scl_rise) begin
                  nack_next = pins.data_or_second_enable;
               end else if (scl_fall) begin
                  cnt_next = `FDCP_CNT_ZERO;
                  if (nack_reg) begin
                     ser_next = fdcp_pkg::FDCP_SER_IDLE;
                  end else begin
                     ser_next       = fdcp_pkg::FDCP_SER_RD;
                     tx_next        = status_byte;
                     drive_low_next = ~status_byte[7];
                  end
               end
            end
            default: begin
               ser_next       = fdcp_pkg::FDCP_SER_IDLE;
               drive_low_next = 1'b0;
            end
         endcase
      end
   end

   // register the serial target state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ser_reg        <= fdcp_pkg::FDCP_SER_IDLE;
         shift_reg      <= `FDCP_BYTE_ZERO;
         tx_reg         <= `FDCP_BYTE_ZERO;
         cnt_reg        <= `FDCP_CNT_ZERO;
         drive_low_reg  <= 1'b0;
         nack_reg       <= 1'b0;
         assist_req_reg <= 1'b0;
         rx_byte_reg    <= `FDCP_BYTE_ZERO;
         rx_valid_reg   <= 1'b0;
      end else begin
         ser_reg        <= ser_next;
         shift_reg      <= shift_next;
         tx_reg         <= tx_next;
         cnt_reg        <= cnt_next;
         drive_low_reg  <= drive_low_next;
         nack_reg       <= nack_next;
         assist_req_reg <= assist_req_next;
         rx_byte_reg    <= rx_byte_next;
         rx_valid_reg   <= rx_valid_next;
      end
   end

   // open-drain data line: only ever pulled low
   assign data_or_second_enable_out = 1'b0;
   assign data_or_second_enable_oe  = drive_low_reg & serial_mode; // RL7
   assign rx_byte                   = rx_byte_reg;
   assign rx_valid                  = rx_valid_reg;

   // ----------------------------------------------------------------
   // mode selection, current level and overvoltage fault
   // ----------------------------------------------------------------
   fdcp_pkg::fdcp_mode_e mode_sel;
   fdcp_pkg::fdcp_drive_s drive_reg;
   fdcp_pkg::fdcp_drive_s drive_next;
   logic ovp_reg;
   logic ovp_next;
   logic strobe_out_reg;
   logic strobe_out_next;
   logic strobe_oe_reg;
   logic strobe_oe_next;

   // flash and assist win over torch in both interface modes
   always_comb begin
      mode_sel = fdcp_pkg::FDCP_MODE_OFF;
      if (!serial_mode) begin
         unique case ({first_enable_bit, second_enable_bit}) // RL10
            2'b00: mode_sel = pins.torch ? fdcp_pkg::FDCP_MODE_TORCH
                                         : fdcp_pkg::FDCP_MODE_OFF; // RL6
            2'b01: mode_sel = fdcp_pkg::FDCP_MODE_ASSIST;
            2'b10: mode_sel = fdcp_pkg::FDCP_MODE_RESERVED;
            2'b11: mode_sel = fdcp_pkg::FDCP_MODE_FLASH;
         endcase
      end else if (pins.strobe) begin
         mode_sel = fdcp_pkg::FDCP_MODE_FLASH; // RL3
      end else if (assist_req_reg) begin
         mode_sel = fdcp_pkg::FDCP_MODE_ASSIST;
      end else if (pins.torch) begin
         mode_sel = fdcp_pkg::FDCP_MODE_TORCH; // RL1
      end
   end

   // fault latches while lit; cleared only by going to off, and a
   // new trip in the same cycle keeps it set
   always_comb begin
      ovp_next = ovp_reg;
      if (mode_sel == fdcp_pkg::FDCP_MODE_OFF) begin
         ovp_next = 1'b0;
      end
      if (pins.ovp_comp && drive_reg.enable) begin
         ovp_next = 1'b1; // RL9
      end
      drive_next.mode    = mode_sel;
      drive_next.current = fdcp_pkg::FDCP_CUR_OFF;
      unique case (mode_sel)
         fdcp_pkg::FDCP_MODE_FLASH:
            drive_next.current = pins.tx_mask ? fdcp_pkg::FDCP_CUR_LOW
                                              : fdcp_pkg::FDCP_CUR_HIGH; // RL2 RL12
         fdcp_pkg::FDCP_MODE_TORCH,
         fdcp_pkg::FDCP_MODE_ASSIST:
            drive_next.current = fdcp_pkg::FDCP_CUR_LOW;
         fdcp_pkg::FDCP_MODE_OFF,
         fdcp_pkg::FDCP_MODE_RESERVED:
            drive_next.current = fdcp_pkg::FDCP_CUR_OFF;
         default:
            drive_next.current = fdcp_pkg::FDCP_CUR_OFF;
      endcase
      if (ovp_next) begin
         drive_next.current = fdcp_pkg::FDCP_CUR_OFF; // RL9
      end
      drive_next.enable = (drive_next.current != fdcp_pkg::FDCP_CUR_OFF);
      strobe_oe_next    = ~serial_mode; // RL3 RL4
      strobe_out_next   = ~serial_mode & pins.led_two; // RL4
   end

   // register the drive outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         drive_reg      <= '{fdcp_pkg::FDCP_MODE_OFF,
                             fdcp_pkg::FDCP_CUR_OFF, 1'b0};
         ovp_reg        <= 1'b0;
         strobe_out_reg <= 1'b0;
         strobe_oe_reg  <= 1'b0;
      end else begin
         drive_reg      <= drive_next;
         ovp_reg        <= ovp_next;
         strobe_out_reg <= strobe_out_next;
         strobe_oe_reg  <= strobe_oe_next;
      end
   end

   assign led_anode_drive = drive_reg;
   assign ovp_fault       = ovp_reg;
   assign strobe_out      = strobe_out_reg;
   assign strobe_oe       = strobe_oe_reg;
endmodule
`default_nettype wire

// [tb/fdcp_host_model.sv]
// host and camera side model: serial master and two-bit enable drive
`timescale 1ns/100ps
`default_nettype none
module fdcp_host_model (
   input  wire logic clk,
   input  wire logic serial,
   input  wire logic en1,
   input  wire logic en2,
   input  wire logic dut_sda_oe,
   output logic      scl,
   output logic      sda
);
   logic scl_reg = 1'b1;
   logic sda_reg = 1'b1;

   // -------------------------------------------------------------
   // shared pins
   // -------------------------------------------------------------
   // data line has a pull-up: a released or undriven line reads high
   assign scl = serial ? scl_reg : en1;
   assign sda = serial ? (sda_reg & !dut_sda_oe) : en2;

   // -------------------------------------------------------------
   // bus cycles
   // -------------------------------------------------------------
   // eight system clocks per phase keeps the synchronisers happy
   task automatic half();
      repeat (8) @(posedge clk);
   endtask

   // data moves only while the clock is low
   task automatic bit_x(input logic b, output logic seen);
      sda_reg <= b;
      half();
      scl_reg <= 1'b1;
      half();
      seen = sda;
      scl_reg <= 1'b0;
      half();
   endtask

   task automatic start();
      sda_reg <= 1'b0;
      half();
      scl_reg <= 1'b0;
      half();
   endtask

   task automatic stop();
      sda_reg <= 1'b0;
      half();
      scl_reg <= 1'b1;
      half();
      sda_reg <= 1'b1;
      half();
   endtask

   // a byte msb first, then the ninth bit; mack high releases the line
   task automatic xfer(input logic [7:0] b, input logic mack,
                       output logic [7:0] got, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], s);
         got[i] = s;
      end
      bit_x(mack, s);
      ack = !s;
   endtask
endmodule
`default_nettype wire

// [tb/fdcp_top_props.sv]
// port assertions for the flash driver control-pin logic
`timescale 1ns/100ps
`default_nettype none
module fdcp_top_props (
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire fdcp_pkg::fdcp_pins_s  pins_in,
   input wire logic                  data_or_second_enable_out,
   input wire logic                  data_or_second_enable_oe,
   input wire logic                  strobe_out,
   input wire logic                  strobe_oe,
   input wire fdcp_pkg::fdcp_drive_s led_anode_drive,
   input wire logic                  ovp_fault,
   input wire logic [7:0]            rx_byte,
   input wire logic                  rx_valid
);
   // -------------------------------------------------------------
   // pins delayed to line up with the registered outputs
   // -------------------------------------------------------------
   fdcp_pkg::fdcp_pins_s  d1_reg;
   fdcp_pkg::fdcp_pins_s  d2_reg;
   fdcp_pkg::fdcp_pins_s  p_reg;
   fdcp_pkg::fdcp_drive_s dr;
   fdcp_pkg::fdcp_mode_e  m2;
   logic [2:0]            age_reg;
   logic                  ok;

   assign dr = led_anode_drive;
   assign ok = (age_reg == 3'h7);

   // two sync stages plus the output register; age masks stale pins
   always_ff @(posedge clk) begin
      d1_reg <= pins_in;
      d2_reg <= d1_reg;
      p_reg  <= d2_reg;
      if (sys_rst)
         age_reg <= 3'h0;
      else if (!ok)
         age_reg <= age_reg + 3'h1;
   end

   // two-bit decode; torch only counts when both bits are low
   always_comb begin
      case ({p_reg.clock_or_first_enable, p_reg.data_or_second_enable})
         2'b00:   m2 = p_reg.torch ? fdcp_pkg::FDCP_MODE_TORCH
                                   : fdcp_pkg::FDCP_MODE_OFF;
         2'b01:   m2 = fdcp_pkg::FDCP_MODE_ASSIST;
         2'b10:   m2 = fdcp_pkg::FDCP_MODE_RESERVED;
         default: m2 = fdcp_pkg::FDCP_MODE_FLASH;
      endcase
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_strobe_dir:
      assert property (ok |-> strobe_oe == !p_reg.if_select)
      else $error("strobe direction wrong");
   chk_led_count:
      assert property (ok && !p_reg.if_select |-> strobe_out == p_reg.led_two)
      else $error("led count on strobe wrong");
   chk_two_bit_mode:
      assert property (ok && !p_reg.if_select |-> dr.mode == m2)
      else $error("two-bit mode decode wrong");
   chk_dark_modes:
      assert property (ok && (dr.mode == fdcp_pkg::FDCP_MODE_OFF ||
         dr.mode == fdcp_pkg::FDCP_MODE_RESERVED) |->
         dr.current == fdcp_pkg::FDCP_CUR_OFF && !dr.enable)
      else $error("dark mode drives current");
   chk_mask_cut:
      assert property (ok && dr.mode == fdcp_pkg::FDCP_MODE_FLASH &&
         dr.enable |-> dr.current == (p_reg.tx_mask ?
         fdcp_pkg::FDCP_CUR_LOW : fdcp_pkg::FDCP_CUR_HIGH))
      else $error("flash current against mask wrong");
   chk_strobe_flash:
      assert property (ok && p_reg.if_select && p_reg.strobe |->
         dr.mode == fdcp_pkg::FDCP_MODE_FLASH)
      else $error("camera strobe gave no flash");
   chk_ovp_trip:
      assert property (ok && d2_reg.ovp_comp && dr.enable |=>
         ovp_fault && !dr.enable)
      else $error("overvoltage did not trip");
   chk_fault_clear:
      assert property ($fell(ovp_fault) |-> dr.mode == fdcp_pkg::FDCP_MODE_OFF)
      else $error("fault cleared outside off mode");
   chk_sda_idle:
      assert property (ok |-> !data_or_second_enable_out &&
         (p_reg.if_select || !data_or_second_enable_oe))
      else $error("data line pulled in two-bit mode");
   chk_rx_pulse:
      assert property (rx_valid |=> !rx_valid)
      else $error("rx_valid longer than one cycle");
   chk_rx_hold:
      assert property (!rx_valid |-> $stable(rx_byte))
      else $error("rx_byte changed without rx_valid");
endmodule

bind fdcp_top fdcp_top_props chk_u (
   .clk(clk), .sys_rst(sys_rst), .pins_in(pins_in),
   .data_or_second_enable_out(data_or_second_enable_out),
   .data_or_second_enable_oe(data_or_second_enable_oe),
   .strobe_out(strobe_out), .strobe_oe(strobe_oe),
   .led_anode_drive(led_anode_drive), .ovp_fault(ovp_fault),
   .rx_byte(rx_byte), .rx_valid(rx_valid)
);
`default_nettype wire

// [tb/fdcp_top_tb.sv]
// self-checking bench for the flash driver control-pin logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module fdcp_top_tb;
   logic                  clk = 1'b0;
   logic                  sys_rst = 1'b1;
   logic                  sel = 1'b0;
   logic                  en1 = 1'b0;
   logic                  en2 = 1'b0;
   logic                  torch = 1'b0;
   logic                  mask = 1'b0;
   logic                  cam = 1'b0;
   logic                  ovp = 1'b0;
   logic                  two = 1'b0;
   logic                  scl, sda, stb, sda_oe, stb_out, stb_oe, fault, ack;
   logic [7:0]            got;
   logic [7:0]            rxb;
   logic                  rxv;
   int                    rx_pulses = 0;
   fdcp_pkg::fdcp_pins_s  pins;
   fdcp_pkg::fdcp_drive_s drv;
   fdcp_pkg::fdcp_mode_e  em;
   int                    bad_count = 0;
   int                    checks = 0;
   int                    seed = 32'h2874;

   always #5 clk = ~clk;
   // the strobe wire: device drives it in two-bit mode, camera otherwise
   assign stb = stb_oe ? stb_out : cam;
   assign pins = {sel, scl, sda, torch, mask, stb, ovp, two};

   // one pulse per written data byte; reads must never raise it
   always @(posedge clk) begin
      if (rxv === 1'b1)
         rx_pulses++;
   end

   fdcp_host_model pm_u (.clk(clk), .serial(sel), .en1(en1), .en2(en2),
      .dut_sda_oe(sda_oe), .scl(scl), .sda(sda));
   fdcp_top dut_u (.clk(clk), .sys_rst(sys_rst), .pins_in(pins),
      .data_or_second_enable_out(), .data_or_second_enable_oe(sda_oe),
      .strobe_out(stb_out), .strobe_oe(stb_oe), .led_anode_drive(drv),
      .ovp_fault(fault), .rx_byte(rxb), .rx_valid(rxv));

   // -------------------------------------------------------------
   // expectations and helpers
   // -------------------------------------------------------------
   function automatic fdcp_pkg::fdcp_mode_e mode_of(logic a, b, t);
      case ({a, b})
         2'b00:   return t ? fdcp_pkg::FDCP_MODE_TORCH
                           : fdcp_pkg::FDCP_MODE_OFF;
         2'b01:   return fdcp_pkg::FDCP_MODE_ASSIST;
         2'b10:   return fdcp_pkg::FDCP_MODE_RESERVED;
         default: return fdcp_pkg::FDCP_MODE_FLASH;
      endcase
   endfunction

   function automatic fdcp_pkg::fdcp_cur_e cur_of(fdcp_pkg::fdcp_mode_e m,
                                                   logic k);
      if (m == fdcp_pkg::FDCP_MODE_FLASH)
         return k ? fdcp_pkg::FDCP_CUR_LOW : fdcp_pkg::FDCP_CUR_HIGH;
      if (m == fdcp_pkg::FDCP_MODE_TORCH || m == fdcp_pkg::FDCP_MODE_ASSIST)
         return fdcp_pkg::FDCP_CUR_LOW;
      return fdcp_pkg::FDCP_CUR_OFF;
   endfunction

   // pins need two sync edges and one output edge; two spare for margin
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
   endtask

   task automatic chk_drive(fdcp_pkg::fdcp_mode_e m, logic k);
      fdcp_pkg::fdcp_cur_e c;
      c = cur_of(m, k);
      `CHK("mode", m, drv.mode)
      `CHK("current", c, drv.current)
      `CHK("enable", c != fdcp_pkg::FDCP_CUR_OFF, drv.enable)
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      // two-bit mode: every enable/torch code first, then random levels
      for (int i = 0; i < 48; i++) begin
         @(posedge clk);
         if (i < 8)
            {en1, en2, torch} <= i[2:0];
         else
            {en1, en2, torch} <= 3'($random(seed));
         {mask, two} <= 2'($random(seed));
         settle();
         em = mode_of(en1, en2, torch);
         chk_drive(em, mask);
         `CHK("strobe_oe", 1'b1, stb_oe)
         `CHK("strobe", two, stb_out)
      end
      // overvoltage: ignored while dark, trips a lit flash, clears on off
      @(posedge clk);
      {en1, en2, torch} <= 3'h0;
      settle();
      ovp <= 1'b1;
      settle();
      `CHK("fault dark", 1'b0, fault)
      @(posedge clk);
      {en1, en2} <= 2'h3;
      settle();
      `CHK("fault", 1'b1, fault)
      `CHK("enable", 1'b0, drv.enable)
      @(posedge clk);
      {en1, en2, ovp} <= 3'h0;
      settle();
      `CHK("fault clear", 1'b0, fault)
      // serial mode: torch held high, assist request must win
      @(posedge clk);
      {sel, torch} <= 2'h3;
      settle();
      `CHK("strobe_oe", 1'b0, stb_oe)
      pm_u.start();
      pm_u.xfer(8'h60, 1'b1, got, ack);
      `CHK("ack", 1'b1, ack)
      pm_u.xfer(8'h01, 1'b1, got, ack);
      `CHK("ack", 1'b1, ack)
      pm_u.stop();
      settle();
      `CHK("rx_byte", 8'h01, rxb)
      `CHK("rx_valid pulses", 1, rx_pulses)
      `CHK("mode", fdcp_pkg::FDCP_MODE_ASSIST, drv.mode)
      @(posedge clk);
      cam <= 1'b1;
      settle();
      `CHK("mode", fdcp_pkg::FDCP_MODE_FLASH, drv.mode)
      @(posedge clk);
      {cam, two} <= 2'h1;
      // a foreign address is left unanswered
      pm_u.start();
      pm_u.xfer(8'h62, 1'b1, got, ack);
      `CHK("ack", 1'b0, ack)
      pm_u.stop();
      // status read: led count bit set, fault bit clear
      pm_u.start();
      pm_u.xfer(8'h61, 1'b1, got, ack);
      `CHK("ack", 1'b1, ack)
      // master acks the first byte, so a second status byte follows
      pm_u.xfer(8'hff, 1'b0, got, ack);
      `CHK("status", 8'h02, got)
      pm_u.xfer(8'hff, 1'b1, got, ack);
      `CHK("status", 8'h02, got)
      pm_u.stop();
      settle();
      `CHK("rx_valid pulses", 1, rx_pulses)
      stop_test();
   end

   // watchdog: the whole run needs well under this many cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire
